// >>> fbmc_host.sv
// host controller that strap-boots the device and downloads a routine over serial
// ------------------------------------------------------------
// Behaviour
// - routine software disables all interrupts, the nonmaskable one too, while flashing.
// - single-chip has normal and user boot; strap pins pick user boot.
// - host sends twelve password bytes; erased flash compares as all ones.
// - downloaded routine must lie within 0xfffd_6000 to 0xfffd_efff inclusive.
// - routine in ram erases flash by block erase or chip erase.
// - after the routine starts, control never returns to the boot rom.
// - in single boot the host talks over serial channel zero.
// - host supplies commands and programming data.
// - host need not erase the old code block beforehand.
// - software should protect reprogrammed blocks once programming ends.
// - the routine may fetch new code over another path or source.
// - single boot: both bus width straps high, boot select low across reset.
// - link is eight data bits, no parity, one stop bit, host baud.
// ------------------------------------------------------------
module fbmc_host
    import fbmc_pkg::*;
#(
    parameter int unsigned BOOT_WAIT_CYC = BOOT_WAIT_US * (CLK_HZ / 1_000_000),
    parameter int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * (CLK_HZ / 1_000_000)
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user requests
    input wire logic start_single,
    input wire logic start_user,
    input wire logic start_normal,
    input wire logic [95:0] password,
    input wire logic [31:0] ram_addr,
    input wire logic [15:0] routine_len,
    // routine byte stream
    input wire logic [7:0] routine_data,
    input wire logic routine_valid,
    output logic routine_take,
    // status
    output logic busy,
    output logic done,
    output logic fail,
    output logic [1:0] fail_code,
    // device pins
    output logic dev_reset_n,
    output logic bus_width_select_low,
    output logic bus_width_select_high,
    output logic boot_select_n,
    output logic user_boot_strap,
    output logic serial_channel_zero_txd,
    input wire logic serial_channel_zero_rxd
);

    typedef struct packed {
        fbmc_state_type state;
        fbmc_phase_type phase;
        fbmc_mode_type mode;
        logic [31:0] cnt;
        logic [3:0] idx;
        logic [15:0] left;
        logic [7:0] sum;
        logic [7:0] expect_ack;
        logic [95:0] pw;
        logic [31:0] addr;
        logic [31:0] lenw;
        logic tx_start;
        logic [7:0] tx_byte;
        logic dev_reset_n;
        logic bw;
        logic boot_n;
        logic user_strap;
        logic busy;
        logic done;
        logic fail;
        fbmc_fail_type code;
        logic take;
    } fbmc_host_state_type;

    fbmc_host_state_type q, d;
    logic tx_done;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [31:0] last_addr;
    logic window_bad;
    logic any_start;

    // ------------------------------------------------------------
    // serial channel zero
    // ------------------------------------------------------------
    fbmc_uart u_uart (
        .clk(clk),
        .rst(rst),
        .tx_start(q.tx_start),
        .tx_byte(q.tx_byte),
        .tx_done(tx_done),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rxd(serial_channel_zero_rxd),
        .txd(serial_channel_zero_txd)
    );

    // wrap-around of the end address counts as outside the window
    assign last_addr = ram_addr + {16'h0, routine_len} - 32'h1;
    assign window_bad = (routine_len == 16'h0) || (ram_addr < RAM_LO)
                        || (last_addr > RAM_HI) || (last_addr < ram_addr);
    assign any_start = start_single || start_user || start_normal;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.tx_start = 1'b0;
        d.take = 1'b0;
        if (any_start && (q.state == S_IDLE || q.state == S_DONE || q.state == S_FAIL))
        begin
            d.busy = 1'b1;
            d.done = 1'b0;
            d.fail = 1'b0;
            d.code = F_NONE;
            d.pw = password;
            d.addr = ram_addr;
            d.lenw = {16'h0, routine_len};
            d.left = routine_len;
            d.sum = 8'h0;
            d.idx = 4'h0;
            d.mode = start_single ? M_SINGLE : (start_user ? M_USER : M_NORMAL);
            if (start_single && window_bad)
            begin
                // refused before the device is touched
                d.busy = 1'b0;
                d.fail = 1'b1;
                d.code = F_ABORT;
                d.state = S_FAIL;
            end
            else
            begin
                d.state = S_RESET;
                d.cnt = RESET_CYC;
                d.dev_reset_n = 1'b0;
                d.bw = start_single ? BW_SINGLE : BW_NORMAL;
                d.boot_n = start_single ? BOOT_SINGLE : BOOT_NORMAL;
                d.user_strap = start_user && !start_single;
            end
        end
        else
        begin
            case (q.state)
                S_RESET:
                begin
                    if (q.cnt != 32'h0)
                    begin
                        d.cnt = q.cnt - 32'h1;
                    end
                    else
                    begin
                        // straps stay put after release so the sample is clean
                        d.dev_reset_n = 1'b1;
                        if (q.mode == M_SINGLE)
                        begin
                            d.state = S_BOOTWAIT;
                            d.cnt = 32'(BOOT_WAIT_CYC);
                        end
                        else
                        begin
                            d.state = S_DONE;
                            d.busy = 1'b0;
                            d.done = 1'b1;
                        end
                    end
                end
                S_BOOTWAIT:
                begin
                    if (q.cnt != 32'h0)
                    begin
                        d.cnt = q.cnt - 32'h1;
                    end
                    else
                    begin
                        d.state = S_SEND;
                        d.phase = P_MODE;
                    end
                end
                S_SEND:
                begin
                    d.tx_start = 1'b1;
                    d.state = S_WAITTX;
                    case (q.phase)
                        P_MODE:
                        begin
                            d.tx_byte = MODE_UART;
                            d.expect_ack = MODE_UART;
                        end
                        P_CMD:
                        begin
                            d.tx_byte = CMD_RAM;
                            d.expect_ack = CMD_RAM;
                        end
                        P_PW:
                        begin
                            d.tx_byte = q.pw[95:88];
                            d.pw = {q.pw[87:0], 8'h0};
                            d.sum = q.sum + q.pw[95:88];
                        end
                        P_SUM:
                        begin
                            d.tx_byte = 8'h0 - q.sum;
                            d.expect_ack = CMD_RAM;
                        end
                        P_ADDR:
                        begin
                            d.tx_byte = q.addr[31:24];
                            d.addr = {q.addr[23:0], 8'h0};
                        end
                        P_LEN:
                        begin
                            d.tx_byte = q.lenw[31:24];
                            d.lenw = {q.lenw[23:0], 8'h0};
                        end
                        default:
                        begin
                            // user stream stalls the download, nothing is sent meanwhile
                            d.tx_start = routine_valid;
                            d.state = routine_valid ? S_WAITTX : S_SEND;
                            d.tx_byte = routine_data;
                            d.take = routine_valid;
                        end
                    endcase
                end
                S_WAITTX:
                begin
                    if (tx_done)
                    begin
                        d.state = S_SEND;
                        d.idx = q.idx + 4'h1;
                        case (q.phase)
                            P_MODE, P_CMD, P_SUM:
                            begin
                                d.state = S_WAITACK;
                                d.cnt = 32'(ACK_TIMEOUT_CYC);
                            end
                            P_PW:
                            begin
                                if (q.idx == PW_LAST)
                                begin
                                    d.phase = P_SUM;
                                end
                            end
                            P_ADDR:
                            begin
                                if (q.idx == WORD_LAST)
                                begin
                                    d.phase = P_LEN;
                                    d.idx = 4'h0;
                                end
                            end
                            P_LEN:
                            begin
                                if (q.idx == WORD_LAST)
                                begin
                                    d.phase = P_DATA;
                                end
                            end
                            default:
                            begin
                                d.left = q.left - 16'h1;
                                if (q.left == 16'h1)
                                begin
                                    // device now runs the routine; host stays silent
                                    d.state = S_DONE;
                                    d.busy = 1'b0;
                                    d.done = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                S_WAITACK:
                begin
                    d.cnt = q.cnt - 32'h1;
                    if (rx_valid && rx_byte == q.expect_ack)
                    begin
                        d.state = S_SEND;
                        d.idx = 4'h0;
                        d.phase = (q.phase == P_MODE) ? P_CMD :
                                  (q.phase == P_CMD) ? P_PW : P_ADDR;
                    end
                    else if (rx_valid || q.cnt == 32'h0)
                    begin
                        // loader is idle now; retry only through a new reset
                        d.state = S_FAIL;
                        d.busy = 1'b0;
                        d.fail = 1'b1;
                        d.code = !rx_valid ? F_ABORT :
                                 (rx_byte[ACK_ERR_BIT] ? F_COMM : F_NAK);
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '{state: S_IDLE, phase: P_MODE, mode: M_NORMAL, code: F_NONE,
                   dev_reset_n: 1'b1, boot_n: BOOT_NORMAL, bw: BW_NORMAL, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign routine_take = q.take;
    assign busy = q.busy;
    assign done = q.done;
    assign fail = q.fail;
    assign fail_code = q.code;
    assign dev_reset_n = q.dev_reset_n;
    assign bus_width_select_low = q.bw;
    assign bus_width_select_high = q.bw;
    assign boot_select_n = q.boot_n;
    assign user_boot_strap = q.user_strap;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [3:0] pw_sent_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pw_sent_q <= 4'h0;
        end
        else if (q.state == S_RESET)
        begin
            pw_sent_q <= 4'h0;
        end
        else if (q.tx_start && q.phase == P_PW)
        begin
            pw_sent_q <= pw_sent_q + 4'h1;
        end
    end

    a_single_straps: assert property (@(posedge clk) disable iff (rst)
        (!q.dev_reset_n && q.mode == M_SINGLE) |-> (q.bw && !q.boot_n))
        else $error("single boot straps wrong during reset");
    a_reset_hold: assert property (@(posedge clk) disable iff (rst)
        $fell(q.dev_reset_n) |-> !q.dev_reset_n [*8])
        else $error("device reset pulse too short");
    a_straps_steady: assert property (@(posedge clk) disable iff (rst)
        $rose(q.dev_reset_n) |=> $stable(q.bw) && $stable(q.boot_n))
        else $error("straps moved at reset release");
    a_pw_twelve: assert property (@(posedge clk) disable iff (rst)
        (q.tx_start && q.phase == P_SUM) |-> pw_sent_q == 4'hc)
        else $error("password not twelve bytes");
    a_sum_zero: assert property (@(posedge clk) disable iff (rst)
        (q.tx_start && q.phase == P_SUM) |-> 8'(q.tx_byte + q.sum) == 8'h0)
        else $error("checksum byte wrong");
    a_window_ok: assert property (@(posedge clk) disable iff (rst)
        (q.state == S_RESET && q.mode == M_SINGLE) |-> (q.addr >= RAM_LO) && (q.lenw != 32'h0)
        && ({1'b0, q.addr} + {1'b0, q.lenw} - 33'h1 <= {1'b0, RAM_HI}))
        else $error("download started outside ram window");
    a_silent_after: assert property (@(posedge clk) disable iff (rst)
        (q.state == S_DONE || q.state == S_FAIL) |-> !q.tx_start && serial_channel_zero_txd)
        else $error("host spoke after download ended");
    a_bad_ack_fails: assert property (@(posedge clk) disable iff (rst)
        (q.state == S_WAITACK && rx_valid && rx_byte != q.expect_ack && !any_start)
        |=> (q.state == S_FAIL && q.fail && !q.busy))
        else $error("bad answer did not abort");

endmodule

// >>> fbmc_pkg.sv
// constants and types shared by the flash boot host controller
package fbmc_pkg;

    // ------------------------------------------------------------
    // clock and serial timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned BAUD_RATE = 115_200;
    localparam logic [15:0] BIT_CNT = 16'(CLK_HZ / BAUD_RATE - 1);
    localparam logic [15:0] HALF_CNT = 16'(CLK_HZ / BAUD_RATE / 2 - 1);
    localparam logic [3:0] TX_BITS = 4'h9;
    localparam logic [3:0] RX_START = 4'h9;
    localparam logic [3:0] RX_FIRST = 4'h8;

    // device reset pulse, least time, rounded up
    localparam int unsigned RESET_HOLD_NS = 2000;
    localparam int unsigned RESET_CYC_I = (RESET_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [31:0] RESET_CYC = 32'(RESET_CYC_I);
    // boot rom start-up time and answer timeout, both long
    localparam int unsigned BOOT_WAIT_US = 1000;
    localparam int unsigned ACK_TIMEOUT_US = 100_000;

    // ------------------------------------------------------------
    // boot protocol bytes
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_UART = 8'h86;
    localparam logic [7:0] CMD_RAM = 8'h10;
    localparam int unsigned ACK_ERR_BIT = 3;
    localparam logic [3:0] PW_LAST = 4'hb;
    localparam logic [3:0] WORD_LAST = 4'h3;
    localparam logic [31:0] RAM_LO = 32'hfffd_6000;
    localparam logic [31:0] RAM_HI = 32'hfffd_efff;

    // ------------------------------------------------------------
    // strap levels
    // ------------------------------------------------------------
    localparam logic BW_SINGLE = 1'b1;
    localparam logic BW_NORMAL = 1'b0;
    localparam logic BOOT_SINGLE = 1'b0;
    localparam logic BOOT_NORMAL = 1'b1;

    typedef enum logic [2:0] {S_IDLE, S_RESET, S_BOOTWAIT, S_SEND, S_WAITTX, S_WAITACK,
                              S_DONE, S_FAIL} fbmc_state_type;
    typedef enum logic [2:0] {P_MODE, P_CMD, P_PW, P_SUM, P_ADDR, P_LEN, P_DATA} fbmc_phase_type;
    typedef enum logic [1:0] {M_NORMAL, M_USER, M_SINGLE} fbmc_mode_type;
    typedef enum logic [1:0] {F_NONE, F_NAK, F_COMM, F_ABORT} fbmc_fail_type;

endpackage

// >>> fbmc_uart.sv
// eight-bit, no parity, one stop bit serial transmitter and receiver
module fbmc_uart
    import fbmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // transmit side
    input wire logic tx_start,
    input wire logic [7:0] tx_byte,
    output logic tx_done,
    // receive side
    output logic rx_valid,
    output logic [7:0] rx_byte,
    // serial pins
    input wire logic rxd,
    output logic txd
);

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_valid;
        logic [7:0] rx_data;
        logic tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic txd;
        logic tx_done;
    } fbmc_uart_state_type;

    fbmc_uart_state_type q, d;

    always_comb
    begin
        d = q;
        d.rx_s1 = rxd;
        d.rx_s2 = q.rx_s1;
        d.rx_valid = 1'b0;
        d.tx_done = 1'b0;
        // ------------------------------------------------------------
        // transmit: start bit, lsb first, stop bit
        // ------------------------------------------------------------
        if (!q.tx_busy)
        begin
            if (tx_start)
            begin
                d.tx_busy = 1'b1;
                d.tx_sh = {1'b1, tx_byte};
                d.txd = 1'b0;
                d.tx_cnt = BIT_CNT;
                d.tx_bit = TX_BITS;
            end
        end
        else if (q.tx_cnt != 16'h0)
        begin
            d.tx_cnt = q.tx_cnt - 16'h1;
        end
        else if (q.tx_bit == 4'h0)
        begin
            d.tx_busy = 1'b0;
            d.tx_done = 1'b1;
        end
        else
        begin
            d.txd = q.tx_sh[0];
            d.tx_sh = {1'b1, q.tx_sh[8:1]};
            d.tx_bit = q.tx_bit - 4'h1;
            d.tx_cnt = BIT_CNT;
        end
        // ------------------------------------------------------------
        // receive: sample mid-bit, glitch on start bit is dropped
        // ------------------------------------------------------------
        if (!q.rx_busy)
        begin
            if (!q.rx_s2)
            begin
                d.rx_busy = 1'b1;
                d.rx_cnt = HALF_CNT;
                d.rx_bit = RX_START;
            end
        end
        else if (q.rx_cnt != 16'h0)
        begin
            d.rx_cnt = q.rx_cnt - 16'h1;
        end
        else if (q.rx_bit == RX_START)
        begin
            d.rx_busy = !q.rx_s2;
            d.rx_bit = RX_FIRST;
            d.rx_cnt = BIT_CNT;
        end
        else if (q.rx_bit != 4'h0)
        begin
            d.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
            d.rx_bit = q.rx_bit - 4'h1;
            d.rx_cnt = BIT_CNT;
        end
        else
        begin
            // a missing stop bit drops the character
            d.rx_busy = 1'b0;
            d.rx_valid = q.rx_s2;
            d.rx_data = q.rx_sh;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '{rx_s1: 1'b1, rx_s2: 1'b1, txd: 1'b1, tx_sh: 9'h1ff, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign tx_done = q.tx_done;
    assign rx_valid = q.rx_valid;
    assign rx_byte = q.rx_data;
    assign txd = q.txd;

    a_tx_line_idle: assert property (@(posedge clk) disable iff (rst)
        !q.tx_busy |-> q.txd) else $error("serial line not idle high");
    // frame too long for a delay range; count busy cycles instead
    logic [15:0] frame_cnt_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            frame_cnt_q <= 16'h0;
        end
        else if (!q.tx_busy)
        begin
            frame_cnt_q <= 16'h0;
        end
        else
        begin
            frame_cnt_q <= frame_cnt_q + 16'h1;
        end
    end

    a_tx_frame_len: assert property (@(posedge clk) disable iff (rst)
        q.tx_done |-> frame_cnt_q == 16'((TX_BITS + 4'h1) * (BIT_CNT + 16'h1)))
        else $error("frame length wrong");

endmodule

// >>> fbmc_dev_model.sv
// behavioural boot rom of the device on the serial link
module fbmc_dev_model
    import fbmc_pkg::*;
(
    // clock and device pins
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bw_lo,
    input wire logic bw_hi,
    input wire logic boot_n,
    input wire logic rxd,
    output logic txd,
    // download seen
    output logic [31:0] addr,
    output logic [7:0] last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] b;
    logic [7:0] s;
    logic [31:0] n;
    // 8n1 at 217 clocks a bit, sampled mid-bit
    task automatic get();
        @(negedge rxd);
        repeat (325) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            b[i] = rxd;
            repeat (217) @(posedge clk);
        end
    endtask
    task automatic put(input logic [7:0] v);
        for (int i = 0; i < 10; i++)
        begin
            txd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i - 1];
            // stop bit stays on the idle line; early return keeps the next start edge in view
            repeat ((i == 9) ? 1 : 217) @(posedge clk);
        end
    endtask
    initial
    begin
        txd = 1'b1;
        addr = 32'h0;
        last = 8'h00;
        forever
        begin
            @(posedge rst_n);
            // straps count only at release; boot rom runs unprivileged
            if (bw_lo && bw_hi && !boot_n)
            begin
                get();
                put(b);
                get();
                put(b);
                s = 8'h00;
                n = 0;
                // erased flash: stored password reads all ones
                repeat (12)
                begin
                    get();
                    s += b;
                    n += (b == 8'hff);
                end
                get();
                s += b;
                put((n == 12 && s == 8'h00) ? CMD_RAM : 8'h11);
                // mismatch leaves ram alone until next reset
                if (n == 12 && s == 8'h00)
                begin
                    repeat (4)
                    begin
                        get();
                        addr = {addr[23:0], b};
                    end
                    repeat (4)
                    begin
                        get();
                        n = {n[23:0], b};
                    end
                    repeat (n)
                    begin
                        get();
                        last = b;
                    end
                end
            end
        end
    end
endmodule

// >>> fbmc_host_tb.sv
// self-checking bench of the flash boot host controller
module fbmc_host_tb;
    import fbmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, ss, su, sn, rv, take, busy, done, fail, rn, bl, bh, bn, ub, txd, rxd;
    logic [95:0] pw;
    logic [31:0] ra, m_addr, seed;
    logic [15:0] rl;
    logic [7:0] rd, d0, d1, m_last;
    logic [1:0] fc;
    int errors, checked, k, takes;
    fbmc_host #(.BOOT_WAIT_CYC(10), .ACK_TIMEOUT_CYC(30000)) dut (.clk(clk), .rst(rst),
        .start_single(ss), .start_user(su), .start_normal(sn), .password(pw), .ram_addr(ra),
        .routine_len(rl), .routine_data(rd), .routine_valid(rv), .routine_take(take),
        .busy(busy), .done(done), .fail(fail), .fail_code(fc), .dev_reset_n(rn),
        .bus_width_select_low(bl), .bus_width_select_high(bh), .boot_select_n(bn),
        .user_boot_strap(ub), .serial_channel_zero_txd(txd), .serial_channel_zero_rxd(rxd));
    fbmc_dev_model dev (.clk(clk), .rst_n(rn), .bw_lo(bl), .bw_hi(bh), .boot_n(bn),
        .rxd(txd), .txd(rxd), .addr(m_addr), .last(m_last));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic close_out();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic kick(input int w);
        @(posedge clk);
        #1 {ss, su, sn} = 3'b100 >> w;
        @(posedge clk);
        #1 {ss, su, sn} = 3'b000;
    endtask
    // bounded wait; a hang ends the run
    task automatic wait_end(input int lim);
        k = 0;
        while (busy !== 1'b0 && k < lim)
        begin
            @(posedge clk);
            #1 k++;
        end
        if (k == lim)
        begin
            errors++;
            close_out();
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // next routine byte once the first is taken
    always @(posedge clk)
        if (take === 1'b1)
        begin
            takes++;
            #1 rd = d1;
        end
    initial
    begin
        {ss, su, sn, rv, rst} = 5'h01;
        pw = '1;
        rl = 16'h0002;
        seed = 32'h0000004d;
        seed = xs(seed);
        ra = RAM_LO + {20'h0, seed[11:0]};
        {d0, d1} = seed[31:16];
        rd = d0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        rv = 1'b1;
        kick(0);
        chk("straps", 32'h6, {bh, bl, bn});
        k = 0;
        while (rn === 1'b0 && k < 100)
        begin
            @(posedge clk);
            #1 k++;
        end
        chk("rst_low", RESET_CYC + 1, k);
        wait_end(90000);
        chk("done", 1, {fail, done});
        chk("addr", ra, m_addr);
        chk("data", d1, m_last);
        chk("takes", {16'h0, rl}, takes);
        rv = 1'b0;
        // wrong password: loader refuses, ram stays as it was
        pw = {3{seed}};
        kick(0);
        wait_end(40000);
        chk("nak", 32'h5, {fail, fc});
        chk("nak_ram", ra, m_addr);
        // window edges, refused before the device is touched
        for (int i = 0; i < 2; i++)
        begin
            ra = i ? RAM_HI : RAM_LO - 1;
            kick(0);
            chk("win_rst", 1, rn);
            wait_end(100);
            chk("win_fail", 32'h7, {fail, fc});
        end
        for (int i = 1; i < 3; i++)
        begin
            kick(i);
            wait_end(200);
            chk("mode", {28'h0, i == 1, 3'h1}, {ub, bh, bl, bn});
            chk("mode_done", 1, done);
        end
        close_out();
    end
endmodule
